// ===== alecb_top.sv
/*
 * APB register bank holding the alarm lock and alert control bits, the
 * limit registers they guard, and an interrupt status/mask pair.
 * Assumes a 32-bit APB master on CLK, a synchronous temperature word and a
 * one-cycle alert response pulse from the serial bus front end.
 */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none

// What this block does
// - While the alarm window lock is set, writes to upper and lower limits are ignored.
// - The alarm window lock resets to 0, reads back 1 once set, and stays set until reset.
// - One write setting the alarm window lock takes effect at once.
// - Writing 1 to alert clear in interrupt mode drops a latched alert; 0 does nothing.
// - In comparator mode, writing 1 to alert clear changes nothing.
// - In interrupt mode, with the bus alert bit 0 clear, an alert response read drops the latched alert.
// - The alert clear bit always reads 0.
// - Alert status reads 1 exactly while the block drives its alert output.
// - Writes to the alert status bit are ignored.
// - The temperature register shows the flags naming the cause of an alert.
// - While either lock is set, the alert output enable cannot be changed.
module alecb_top
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST,
    // APB slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [7:0]                    PADDR,
    input  wire logic [31:0]                   PWDATA,
    output logic                               PREADY,
    output logic [31:0]                        PRDATA,
    output logic                               PSLVERR,
    // Sensor side
    input  wire logic [alecb_pkg::TEMP_W-1:0] TEMP_VALUE,
    input  wire logic                          ARA_READ,
    // Outputs
    output logic                               ALERT_OUT,
    output logic                               IRQ
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    alecb_pkg::alecb_apb_state_t state_reg;
    logic                         mode_reg;
    logic                         oe_reg;
    logic                         awl_reg;
    logic                         ctl_reg;
    logic                         ara_dis_reg;
    logic [alecb_pkg::TEMP_W-1:0] upper_reg;
    logic [alecb_pkg::TEMP_W-1:0] lower_reg;
    logic [alecb_pkg::TEMP_W-1:0] crit_reg;
    logic [alecb_pkg::IRQ_W-1:0]  irq_stat_reg;
    logic [alecb_pkg::IRQ_W-1:0]  irq_mask_reg;
    logic [alecb_pkg::IRQ_W-1:0]  irq_set;
    logic [alecb_pkg::IRQ_W-1:0]  irq_stat_next;
    logic                         alert_reg;
    logic                         irq_reg;
    logic                         pready_reg;
    logic                         pslverr_reg;
    logic [31:0]                  prdata_reg;
    logic                         wr_commit;
    logic                         wr_cfg;
    logic                         clear_req;
    logic                         locked;
    logic                         refused;
    logic                         active;
    alecb_pkg::alecb_flags_t      flags;
    logic [31:0]                  read_word;

    // Address decode shared by read mux, error answer and write strobes
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        addr_is = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = addr_is(a, alecb_pkg::CFG_OFF) | addr_is(a, alecb_pkg::UPPER_OFF)
               | addr_is(a, alecb_pkg::LOWER_OFF) | addr_is(a, alecb_pkg::CRIT_OFF)
               | addr_is(a, alecb_pkg::TEMP_OFF) | addr_is(a, alecb_pkg::BUS_OFF)
               | addr_is(a, alecb_pkg::IRQ_STAT_OFF) | addr_is(a, alecb_pkg::IRQ_MASK_OFF);
    endfunction

    // ------------------------------------------------------------------
    // APB sequencing
    // ------------------------------------------------------------------
    // One wait state: PREADY rises in the second access cycle, so read data
    // always comes from a flop and writes land at the sampling edge.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg   <= alecb_pkg::ALECB_IDLE;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            case (state_reg)
                alecb_pkg::ALECB_IDLE:
                begin
                    if (PSEL && PENABLE)
                    begin
                        state_reg   <= alecb_pkg::ALECB_ANSWER;
                        pready_reg  <= 1'b1;
                        pslverr_reg <= ~mapped(PADDR);
                        prdata_reg  <= PWRITE ? 32'h0000_0000 : read_word;
                    end
                end
                alecb_pkg::ALECB_ANSWER:
                begin
                    state_reg   <= alecb_pkg::ALECB_IDLE;
                    pready_reg  <= 1'b0;
                    pslverr_reg <= 1'b0;
                    prdata_reg  <= 32'h0000_0000;
                end
                default:
                begin
                    state_reg  <= alecb_pkg::ALECB_IDLE;
                    pready_reg <= 1'b0;
                end
            endcase
        end
    end

    assign wr_commit = (state_reg == alecb_pkg::ALECB_ANSWER) & PSEL & PENABLE & PWRITE;
    assign wr_cfg    = wr_commit & addr_is(PADDR, alecb_pkg::CFG_OFF);
    assign locked    = awl_reg | ctl_reg;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Clear bit is never stored, so it reads back as 0 by construction
    always_comb
    begin
        read_word = 32'h0000_0000;
        if (addr_is(PADDR, alecb_pkg::CFG_OFF))
        begin
            read_word[alecb_pkg::MODE_BIT] = mode_reg;
            read_word[alecb_pkg::OE_BIT]   = oe_reg;
            read_word[alecb_pkg::STAT_BIT] = alert_reg;
            read_word[alecb_pkg::CLR_BIT]  = 1'b0;
            read_word[alecb_pkg::AWL_BIT]  = awl_reg;
            read_word[alecb_pkg::CTL_BIT]  = ctl_reg;
        end
        else if (addr_is(PADDR, alecb_pkg::UPPER_OFF))
            read_word[alecb_pkg::TEMP_W-1:0] = upper_reg;
        else if (addr_is(PADDR, alecb_pkg::LOWER_OFF))
            read_word[alecb_pkg::TEMP_W-1:0] = lower_reg;
        else if (addr_is(PADDR, alecb_pkg::CRIT_OFF))
            read_word[alecb_pkg::TEMP_W-1:0] = crit_reg;
        else if (addr_is(PADDR, alecb_pkg::TEMP_OFF))
        begin
            read_word[alecb_pkg::TEMP_W-1:0]                  = TEMP_VALUE;
            read_word[alecb_pkg::FLAG_LSB+2:alecb_pkg::FLAG_LSB] = flags;
        end
        else if (addr_is(PADDR, alecb_pkg::BUS_OFF))
            read_word[alecb_pkg::ARA_DIS_BIT] = ara_dis_reg;
        else if (addr_is(PADDR, alecb_pkg::IRQ_STAT_OFF))
            read_word[alecb_pkg::IRQ_W-1:0] = irq_stat_reg;
        else if (addr_is(PADDR, alecb_pkg::IRQ_MASK_OFF))
            read_word[alecb_pkg::IRQ_W-1:0] = irq_mask_reg;
    end

    // ------------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------------
    // Locks are sticky: only reset clears them, a single write sets them
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            awl_reg <= alecb_pkg::BIT_RST;
            ctl_reg <= alecb_pkg::BIT_RST;
        end
        else if (wr_cfg)
        begin
            awl_reg <= awl_reg | PWDATA[alecb_pkg::AWL_BIT];
            ctl_reg <= ctl_reg | PWDATA[alecb_pkg::CTL_BIT];
        end
    end

    // Enable is frozen while locked; the status bit has no storage to write
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            oe_reg   <= alecb_pkg::BIT_RST;
            mode_reg <= alecb_pkg::BIT_RST;
        end
        else if (wr_cfg)
        begin
            mode_reg <= PWDATA[alecb_pkg::MODE_BIT];
            if (!locked)
                oe_reg <= PWDATA[alecb_pkg::OE_BIT];
        end
    end

    // Clear is a strobe, only a 1 does anything
    assign clear_req = wr_cfg & PWDATA[alecb_pkg::CLR_BIT];

    always_ff @(posedge CLK)
    begin
        if (RST)
            ara_dis_reg <= alecb_pkg::BIT_RST;
        else if (wr_commit && addr_is(PADDR, alecb_pkg::BUS_OFF))
            ara_dis_reg <= PWDATA[alecb_pkg::ARA_DIS_BIT];
    end

    // ------------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------------
    // Locked writes complete on the bus normally but leave the limits alone
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            upper_reg <= alecb_pkg::LIMIT_RST;
            lower_reg <= alecb_pkg::LIMIT_RST;
            crit_reg  <= alecb_pkg::CRIT_RST;
        end
        else if (wr_commit)
        begin
            if (addr_is(PADDR, alecb_pkg::UPPER_OFF) && !awl_reg)
                upper_reg <= PWDATA[alecb_pkg::TEMP_W-1:0];
            if (addr_is(PADDR, alecb_pkg::LOWER_OFF) && !awl_reg)
                lower_reg <= PWDATA[alecb_pkg::TEMP_W-1:0];
            if (addr_is(PADDR, alecb_pkg::CRIT_OFF) && !ctl_reg)
                crit_reg  <= PWDATA[alecb_pkg::TEMP_W-1:0];
        end
    end

    // A refused write is flagged so software can notice it
    assign refused = wr_commit & (
          (awl_reg & (addr_is(PADDR, alecb_pkg::UPPER_OFF)
                    | addr_is(PADDR, alecb_pkg::LOWER_OFF)))
        | (ctl_reg & addr_is(PADDR, alecb_pkg::CRIT_OFF))
        | (wr_cfg & locked & (PWDATA[alecb_pkg::OE_BIT] != oe_reg)));

    // ------------------------------------------------------------------
    // Alert engine
    // ------------------------------------------------------------------
    alecb_event u_event
    (
        .clk         (CLK),
        .rst         (RST),
        .temp        (TEMP_VALUE),
        .upper       (upper_reg),
        .lower       (lower_reg),
        .crit        (crit_reg),
        .int_mode    (mode_reg),
        .clear_req   (clear_req),
        .ara_req     (ARA_READ),
        .ara_disable (ara_dis_reg),
        .flags       (flags),
        .active      (active)
    );

    // Pin drive and status share this flop so they can never disagree
    always_ff @(posedge CLK)
    begin
        if (RST)
            alert_reg <= alecb_pkg::BIT_RST;
        else
            alert_reg <= oe_reg & active;
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    assign irq_set[alecb_pkg::IRQ_ALERT]   = (oe_reg & active) & ~alert_reg;
    assign irq_set[alecb_pkg::IRQ_REFUSED] = refused;

    // Write-one-to-clear; a new event in the clear cycle still lands
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (wr_commit && addr_is(PADDR, alecb_pkg::IRQ_STAT_OFF))
            irq_stat_next = irq_stat_reg & ~PWDATA[alecb_pkg::IRQ_W-1:0];
        irq_stat_next = irq_stat_next | irq_set;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            irq_stat_reg <= alecb_pkg::IRQ_RST;
            irq_mask_reg <= alecb_pkg::IRQ_RST;
            irq_reg      <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            if (wr_commit && addr_is(PADDR, alecb_pkg::IRQ_MASK_OFF))
                irq_mask_reg <= PWDATA[alecb_pkg::IRQ_W-1:0];
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PREADY    = pready_reg;
    assign PRDATA    = prdata_reg;
    assign PSLVERR   = pslverr_reg;
    assign ALERT_OUT = alert_reg;
    assign IRQ       = irq_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_LIMIT_LOCKED: assert property (@(posedge CLK) disable iff (RST)
        wr_commit && awl_reg && addr_is(PADDR, alecb_pkg::UPPER_OFF)
        |=> $stable(upper_reg))
        else $error("Upper limit changed while locked");
    AST_LOCK_HOLDS: assert property (@(posedge CLK) disable iff (RST)
        awl_reg |=> awl_reg [*3])
        else $error("Window lock dropped without reset");
    AST_LOCK_SINGLE: assert property (@(posedge CLK) disable iff (RST)
        wr_cfg && PWDATA[alecb_pkg::AWL_BIT] |=> awl_reg)
        else $error("Single write did not set window lock");
    AST_CLEAR_READS0: assert property (@(posedge CLK) disable iff (RST)
        PREADY && addr_is(PADDR, alecb_pkg::CFG_OFF) && !PWRITE
        |-> !PRDATA[alecb_pkg::CLR_BIT])
        else $error("Clear bit read back nonzero");
    AST_STATUS_MATCH: assert property (@(posedge CLK) disable iff (RST)
        PREADY && addr_is(PADDR, alecb_pkg::CFG_OFF) && !PWRITE
        |-> PRDATA[alecb_pkg::STAT_BIT] == $past(ALERT_OUT))
        else $error("Status bit disagrees with alert output");
    AST_STATUS_WR: assert property (@(posedge CLK) disable iff (RST)
        wr_cfg && PWDATA[alecb_pkg::STAT_BIT] && !(oe_reg && active) |=> !ALERT_OUT)
        else $error("Status write drove the alert output");
    AST_FLAGS_SHOWN: assert property (@(posedge CLK) disable iff (RST)
        PREADY && addr_is(PADDR, alecb_pkg::TEMP_OFF) && !PWRITE
        |-> PRDATA[alecb_pkg::FLAG_LSB+2:alecb_pkg::FLAG_LSB] == $past(flags))
        else $error("Temperature flags missing from read");
    AST_OE_LOCKED: assert property (@(posedge CLK) disable iff (RST)
        wr_cfg && locked |=> oe_reg == $past(oe_reg))
        else $error("Output enable changed while locked");

endmodule

`default_nettype wire

// ===== alecb_pkg.sv
/*
 * Shared constants and types for the alert lock and event control block.
 * Assumes a 32-bit APB master and a synchronous temperature word source.
 */
`default_nettype none

package alecb_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_OFF      = 8'h00;
    localparam logic [7:0] UPPER_OFF    = 8'h04;
    localparam logic [7:0] LOWER_OFF    = 8'h08;
    localparam logic [7:0] CRIT_OFF     = 8'h0C;
    localparam logic [7:0] TEMP_OFF     = 8'h10;
    localparam logic [7:0] BUS_OFF      = 8'h14;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h18;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MODE_BIT    = 0;  // 1 = interrupt mode, 0 = comparator
    localparam int OE_BIT      = 3;
    localparam int STAT_BIT    = 4;
    localparam int CLR_BIT     = 5;
    localparam int AWL_BIT     = 6;
    localparam int CTL_BIT     = 7;
    localparam int ARA_DIS_BIT = 0;
    localparam int FLAG_LSB    = 13; // Flags sit in temperature bits 15:13
    localparam int IRQ_ALERT   = 0;  // Alert output rose
    localparam int IRQ_REFUSED = 1;  // A write was refused by a lock
    localparam int TEMP_W      = 13;
    localparam int IRQ_W       = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [TEMP_W-1:0] LIMIT_RST = 13'h0000;
    localparam logic [TEMP_W-1:0] CRIT_RST  = 13'h0000;
    localparam logic [IRQ_W-1:0]  IRQ_RST   = 2'h0;
    localparam logic              BIT_RST   = 1'b0;

    // Which limit conditions are present in the current sample
    typedef struct packed {
        logic crit;
        logic above;
        logic below;
    } alecb_flags_t;

    // APB access sequencing
    typedef enum logic [1:0] {
        ALECB_IDLE   = 2'b00,
        ALECB_ANSWER = 2'b01
    } alecb_apb_state_t;

endpackage

`default_nettype wire

// ===== alecb_event.sv
/*
 * Limit comparison and alert latch.
 * Assumes the temperature word and limits are stable, signed, synchronous.
 */
`default_nettype none

module alecb_event
(
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // Sample and limits
    input  wire logic [alecb_pkg::TEMP_W-1:0] temp,
    input  wire logic [alecb_pkg::TEMP_W-1:0] upper,
    input  wire logic [alecb_pkg::TEMP_W-1:0] lower,
    input  wire logic [alecb_pkg::TEMP_W-1:0] crit,
    // Control
    input  wire logic                          int_mode,
    input  wire logic                          clear_req,
    input  wire logic                          ara_req,
    input  wire logic                          ara_disable,
    // Results
    output alecb_pkg::alecb_flags_t            flags,
    output logic                               active
);

    alecb_pkg::alecb_flags_t flags_next;
    logic                    cond_reg;
    logic                    latch_reg;
    logic                    set_ev;
    logic                    clr_ev;

    // Signed compares against the three limits
    always_comb
    begin
        flags_next.crit  = $signed(temp) >= $signed(crit);
        flags_next.above = $signed(temp) > $signed(upper);
        flags_next.below = $signed(temp) < $signed(lower);
    end

    // Latch sets on a new condition; a set in the clear cycle wins
    assign set_ev = (|flags_next) & ~cond_reg;
    assign clr_ev = int_mode & (clear_req | (ara_req & ~ara_disable));

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags     <= '0;
            cond_reg  <= alecb_pkg::BIT_RST;
            latch_reg <= alecb_pkg::BIT_RST;
        end
        else
        begin
            flags    <= flags_next;
            cond_reg <= |flags_next;
            if (set_ev)
                latch_reg <= 1'b1;
            else if (clr_ev)
                latch_reg <= 1'b0;
        end
    end

    // Comparator mode follows the condition; interrupt mode holds the latch
    assign active = int_mode ? latch_reg : cond_reg;

    AST_CMP_CLEAR: assert property (@(posedge clk) disable iff (rst)
        !int_mode && clear_req && !set_ev |=> $stable(latch_reg))
        else $error("Clear altered state in comparator mode");
    AST_INT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        int_mode && clear_req && !set_ev |=> !latch_reg)
        else $error("Clear did not drop latched alert");
    AST_ARA_CLEAR: assert property (@(posedge clk) disable iff (rst)
        int_mode && ara_req && !ara_disable && !set_ev |=> !latch_reg)
        else $error("Alert response did not drop latched alert");

endmodule

`default_nettype wire

// ===== alecb_host_model.sv
/*
 * Behavioural stand-in for the serial bus host and sensor front end.
 * Assumes the bench asks for one-cycle alert response reads on clk.
 */
`default_nettype none

module alecb_host_model
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench requests
    input  wire logic [12:0] temp_set,
    input  wire logic        ara_go,
    // Toward the block
    output logic      [12:0] temp_value,
    output logic             ara_read
);
    timeunit 1ns;
    timeprecision 1ps;

    // Sample and alert response pulse, both launched just after an edge
    always_ff @(posedge clk)
    begin
        temp_value <= temp_set;
        ara_read   <= ara_go & ~rst;
    end
endmodule

`default_nettype wire

// ===== alecb_tb.sv
/*
 * Self-checking bench for the alert lock and event control bank.
 * Assumes the host model supplies the sample and alert response pulses.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rdata;
    logic PREADY, PSLVERR, ARA_READ, ALERT_OUT, IRQ, rerr, ara_go = 1'b0;
    logic [12:0] TEMP_VALUE, temp_set = 13'h0010;
    int errors = 0, checks_done = 0;

    always #5 CLK = ~CLK;

    alecb_top u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
        .PRDATA(PRDATA), .PSLVERR(PSLVERR), .TEMP_VALUE(TEMP_VALUE),
        .ARA_READ(ARA_READ), .ALERT_OUT(ALERT_OUT), .IRQ(IRQ));
    alecb_host_model u_host (.clk(CLK), .rst(RST), .temp_set(temp_set),
        .ara_go(ara_go), .temp_value(TEMP_VALUE), .ara_read(ARA_READ));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle cycle follows so no strobe is set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h1, 32'h0);
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask

    // Move the sample, give the latch its two edges plus margin
    task automatic temp_to(input logic [12:0] t);
        temp_set <= t;
        cyc(5);
    endtask

    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_reset_and_limits();
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata & 32'hEF, 32'h0);
        apb(1, alecb_pkg::CRIT_OFF, 32'h0FFF);
        apb(1, alecb_pkg::UPPER_OFF, 32'h20);
        apb(0, alecb_pkg::UPPER_OFF, 0);
        chk(rdata, 32'h20);
    endtask

    // Latched alert, cause flags, clear bit, status write, alert response
    task automatic s_interrupt_mode();
        apb(1, alecb_pkg::CFG_OFF, 32'h09);
        temp_to(13'h0030);
        chk(ALERT_OUT, 1'b1);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata, 32'h19);
        apb(0, alecb_pkg::TEMP_OFF, 0);
        chk(rdata, 32'h4030);
        apb(1, alecb_pkg::CFG_OFF, 32'h19);
        cyc(2);
        chk(ALERT_OUT, 1'b1);
        apb(1, alecb_pkg::CFG_OFF, 32'h29);
        cyc(2);
        chk(ALERT_OUT, 1'b0);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata, 32'h09);
        temp_to(13'h0010);
        temp_to(13'h0030);
        ara_go <= 1'b1;
        cyc(1);
        ara_go <= 1'b0;
        cyc(3);
        chk(ALERT_OUT, 1'b0);
        apb(1, alecb_pkg::BUS_OFF, 32'h1);
        temp_to(13'h0010);
        temp_to(13'h0030);
        ara_go <= 1'b1;
        cyc(1);
        ara_go <= 1'b0;
        cyc(3);
        chk(ALERT_OUT, 1'b1);
        apb(1, alecb_pkg::BUS_OFF, 32'h0);
    endtask

    // Sticky status, mask gating the interrupt, write-one-to-clear
    task automatic s_irq();
        apb(0, alecb_pkg::IRQ_STAT_OFF, 0);
        chk(rdata, 32'h1);
        chk(IRQ, 1'b0);
        apb(1, alecb_pkg::IRQ_MASK_OFF, 32'h3);
        cyc(2);
        chk(IRQ, 1'b1);
        apb(1, alecb_pkg::IRQ_STAT_OFF, 32'h1);
        cyc(2);
        chk(IRQ, 1'b0);
    endtask

    // Comparator mode ignores the clear bit; unmapped access is refused
    task automatic s_comparator();
        apb(1, alecb_pkg::CFG_OFF, 32'h08);
        cyc(3);
        apb(1, alecb_pkg::CFG_OFF, 32'h28);
        cyc(2);
        chk(ALERT_OUT, 1'b1);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata, 32'h18);
        apb(0, 8'h40, 0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdata, 32'h0);
    endtask

    // Lock takes at once, sticks, freezes limits and output enable
    task automatic s_lock();
        apb(1, alecb_pkg::CFG_OFF, 32'h48);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata & 32'hEF, 32'h48);
        apb(1, alecb_pkg::CFG_OFF, 32'h00);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata & 32'hEF, 32'h48);
        apb(1, alecb_pkg::UPPER_OFF, 32'h05);
        apb(0, alecb_pkg::UPPER_OFF, 0);
        chk(rdata, 32'h20);
        apb(0, alecb_pkg::IRQ_STAT_OFF, 0);
        chk(rdata & 32'h2, 32'h2);
        RST <= 1'b1;
        cyc(3);
        RST <= 1'b0;
        cyc(1);
        // Status bit written while the pin is disabled must not raise it
        apb(1, alecb_pkg::CFG_OFF, 32'h10);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata, 32'h0);
        // Critical lock alone freezes the enable and the critical limit
        apb(1, alecb_pkg::CFG_OFF, 32'h80);
        apb(1, alecb_pkg::CFG_OFF, 32'h08);
        apb(0, alecb_pkg::CFG_OFF, 0);
        chk(rdata & 32'hEF, 32'h80);
        apb(1, alecb_pkg::CRIT_OFF, 32'h05);
        apb(0, alecb_pkg::CRIT_OFF, 0);
        chk(rdata, 32'h0);
        apb(1, alecb_pkg::UPPER_OFF, 32'h05);
        apb(0, alecb_pkg::UPPER_OFF, 0);
        chk(rdata, 32'h05);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        cyc(20);
        RST <= 1'b0;
        cyc(1);
        s_reset_and_limits();
        s_interrupt_mode();
        s_irq();
        s_comparator();
        s_lock();
        tally_and_finish();
    end

    // Whole run is a few hundred cycles; this is generous
    initial
    begin
        cyc(20000);
        errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
